/* File: core/pmdc_cfg.svh */
`ifndef PMDC_CFG_SVH
`define PMDC_CFG_SVH

`define PMDC_CLK_NS     50
`define PMDC_LOS_NS     3200
`define PMDC_LOS_CYC    (`PMDC_LOS_NS / `PMDC_CLK_NS)
`define PMDC_LOS_W      7
`define PMDC_LOS_LAST   7'(`PMDC_LOS_CYC - 1)

`define PMDC_NCH        8
`define PMDC_NOUT       16
`define PMDC_DLY        16
`define PMDC_DLY_W      4

`define PMDC_SRC_LOOP_A 2'h0
`define PMDC_SRC_LOOP_B 2'h1
`define PMDC_SRC_OSC    2'h2
`define PMDC_SRC_FANOUT 2'h3

`define PMDC_REF_MAN0   2'h0
`define PMDC_REF_MAN1   2'h1

`define PMDC_GPIO_IN    2'h0
`define PMDC_GPIO_OUT   2'h1
`define PMDC_GPIO_CTRL  2'h2
`define PMDC_GPIO_STAT  2'h3

`define PMDC_PD_INPUT   0
`define PMDC_PD_LOOP0   1
`define PMDC_PD_LOOP1   2

`define PMDC_BASE_MAX   3'h5
`define PMDC_POW_MAX    4'hc
`define PMDC_SR_MIN     4'h1
`define PMDC_RST_RATIO  15'h0001

`endif

/* File: core/pmdc_pkg.sv */
package pmdc_pkg;
`include "pmdc_cfg.svh"

   typedef enum logic [2:0] {
      PMDC_DUAL,
      PMDC_SYNTH,
      PMDC_OSC_ONLY,
      PMDC_FANOUT,
      PMDC_INVALID
   } pmdc_mode_t;

   typedef struct packed {
      logic [14:0] cnt;
      logic [14:0] ratio;
      logic        tick;
   } pmdc_div_st_t;

   typedef struct packed {
      logic [1:0][2:0]                           ref_s;
      logic [1:0]                                ref_lvl;
      logic [1:0][`PMDC_LOS_W-1:0]               los_cnt;
      logic [1:0]                                los;
      logic                                      act_ref;
      logic                                      holdover;
      logic [1:0][2:0]                           gpio_s;
      logic [1:0]                                gpio_lvl;
      logic [1:0]                                gpio_pin;
      logic [1:0]                                gpio_oe;
      logic                                      halve_ph;
      logic                                      resync;
      logic [`PMDC_NCH-1:0][`PMDC_DLY-1:0]       ch_dly;
      logic [`PMDC_NOUT-1:0][`PMDC_DLY-1:0]      out_dly;
      logic [`PMDC_NOUT-1:0]                     q_out;
      pmdc_mode_t                                mode;
      logic                                      determ;
      logic                                      central;
      logic [3:0]                                pfd;
   } pmdc_st_t;

endpackage

/* File: core/pmdc_div.sv */
`timescale 1ns/1ps
module pmdc_div (
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        restart_i,
   input  wire logic        en_i,
   input  wire logic        dbl_i,
   input  wire logic [14:0] ratio_i,
   output wire logic        tick_o,
   output wire logic        chg_o
);
   import pmdc_pkg::*;

   pmdc_div_st_t q;
   pmdc_div_st_t d;
   logic [14:0]  r;
   logic [15:0]  s;
   logic [15:0]  w;

   // Ratio zero would tick on every enabled input; treat it as divide by one
   assign r      = (ratio_i == 15'h0) ? 15'h1 : ratio_i;
   assign chg_o  = (r != q.ratio);
   assign tick_o = q.tick;

   always_comb begin
      d      = q;
      d.tick = 1'b0;
      s      = {1'b0, q.cnt} + (dbl_i ? 16'h2 : 16'h1);
      w      = s - {1'b0, q.ratio};
      if (restart_i || chg_o) begin
         d.cnt   = 15'h0;
         d.ratio = r;
      end else if (en_i) begin
         if (s >= {1'b0, q.ratio}) begin
            d.tick = 1'b1;
            // Double step on ratio one cannot give two ticks per input
            d.cnt  = (w >= {1'b0, q.ratio}) ? 15'h0 : w[14:0];
         end else begin
            d.cnt = s[14:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         q <= '{cnt: 15'h0, ratio: `PMDC_RST_RATIO, tick: 1'b0};
      end else begin
         q <= d;
      end
   end

endmodule // pmdc_div

/* File: core/pmdc_top.sv */
// Behaviour
// - Bypass and source select pick dual-loop mode
// - Bypass set, source 00/01 gives synthesizer
// - Oscillator-only mode bypasses second loop
// - Deterministic delay only dual mode, route one
// - First-loop pre and feedback: 15-bit dividers
// - Cascade feedback divider: 14-bit, up to 16383
// - Second-loop pre-divider: 7-bit, up to 127
// - Second-loop feedback divider: 10-bit, up to 1023
// - Doubler halves effective second-loop pre-divide
// - Clock divider {1..5} times two to m
// - SYSREF adds two to p, p 1..12
// - Eight channels, each clock or SYSREF
// - SYSREF synchronous, dividers from central reference
// - Phase delay per channel and per output
// - Outputs, channels, blocks can power down
// - Two references, priority auto-select, holdover
// - Configuration and status readable back
// - Two pins: GPIO, control input, status output
`timescale 1ns/1ps
module pmdc_top (
   input  wire logic                               clk_i,
   input  wire logic                               rst_b_i,
   input  wire logic                               first_loop_bypass_i,
   input  wire logic [1:0]                         central_source_select_i,
   input  wire logic                               first_loop_feedback_route_i,
   input  wire logic                               second_loop_doubler_i,
   input  wire logic                               ext_osc_halve_select_i,
   input  wire logic [1:0]                         input_div_sel_i,
   input  wire logic [14:0]                        first_loop_pre_divider_i,
   input  wire logic [14:0]                        first_loop_feedback_divider_i,
   input  wire logic [13:0]                        cascade_feedback_divider_i,
   input  wire logic [6:0]                         second_loop_pre_divider_i,
   input  wire logic [9:0]                         second_loop_feedback_divider_i,
   input  wire logic [`PMDC_NCH-1:0][2:0]          ch_base_i,
   input  wire logic [`PMDC_NCH-1:0][3:0]          ch_pow_i,
   input  wire logic [`PMDC_NCH-1:0]               ch_sysref_i,
   input  wire logic [`PMDC_NCH-1:0][3:0]          ch_sr_pow_i,
   input  wire logic [`PMDC_NCH-1:0][`PMDC_DLY_W-1:0] ch_phase_i,
   input  wire logic [`PMDC_NOUT-1:0][`PMDC_DLY_W-1:0] out_phase_i,
   input  wire logic [`PMDC_NCH-1:0]               ch_pd_i,
   input  wire logic [`PMDC_NOUT-1:0]              out_pd_i,
   input  wire logic [2:0]                         blk_pd_i,
   input  wire logic [1:0]                         ref_in_i,
   input  wire logic [1:0]                         ref_mode_i,
   input  wire logic                               ref_prio_i,
   input  wire logic                               vcxo_tick_i,
   input  wire logic                               vco_tick_i,
   input  wire logic [1:0][1:0]                    gpio_func_i,
   input  wire logic [1:0]                         gpio_val_i,
   input  wire logic [1:0]                         gpio_i,
   output wire logic [1:0]                         gpio_o,
   output wire logic [1:0]                         gpio_oe_o,
   output wire logic [1:0]                         gpio_in_o,
   output wire logic [`PMDC_NOUT-1:0]              q_out_o,
   output wire pmdc_pkg::pmdc_mode_t               mode_o,
   output wire logic                               deterministic_o,
   output wire logic                               central_tick_o,
   output wire logic                               active_ref_o,
   output wire logic                               holdover_o,
   output wire logic [1:0]                         ref_los_o,
   output wire logic                               pfd0_ref_o,
   output wire logic                               pfd0_fb_o,
   output wire logic                               pfd1_ref_o,
   output wire logic                               pfd1_fb_o
);
   import pmdc_pkg::*;

   pmdc_st_t             q;
   pmdc_st_t             d;
   pmdc_mode_t           mode_c;
   logic [1:0]           ref_edge;
   logic [1:0]           gpio_rise;
   logic                 sel_tick;
   logic                 osc_tick;
   logic                 ct;
   logic                 rn_tick;
   logic                 p0_tick;
   logic                 m0_tick;
   logic                 m1_tick;
   logic                 p1_tick;
   logic                 m2_tick;
   logic [5:0]           loop_chg;
   logic [`PMDC_NCH-1:0] base_tick;
   logic [`PMDC_NCH-1:0] clk_tick;
   logic [`PMDC_NCH-1:0] sr_tick;
   logic [`PMDC_NCH-1:0] ch_out;
   logic [`PMDC_NCH-1:0] ch_rst;
   logic [3*`PMDC_NCH-1:0] ch_chg;
   logic                 rst_in;
   logic                 rst_l0;
   logic                 rst_l1;
   logic                 rst_p1;

   // Source 11 without bypass has no defined mode; the outputs stay idle
   assign mode_c = (central_source_select_i == `PMDC_SRC_OSC) ? PMDC_OSC_ONLY
      : (central_source_select_i == `PMDC_SRC_FANOUT)
         ? (first_loop_bypass_i ? PMDC_FANOUT : PMDC_INVALID)
      : (first_loop_bypass_i ? PMDC_SYNTH : PMDC_DUAL);

   // Level accepted only when second and third flops agree
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_pin
         assign ref_edge[gi]  = (q.ref_s[gi][2] == q.ref_s[gi][1])
                                & q.ref_s[gi][1] & ~q.ref_lvl[gi];
         assign gpio_rise[gi] = (q.gpio_s[gi][2] == q.gpio_s[gi][1])
                                & q.gpio_s[gi][1] & ~q.gpio_lvl[gi];
      end
   endgenerate

   assign sel_tick = ~q.holdover & ref_edge[q.act_ref];
   // External oscillator halving keeps every other edge
   assign osc_tick = vco_tick_i
                     & (~ext_osc_halve_select_i | q.halve_ph);

   // Central timing point: second loop, else first loop, else input
   always_comb begin
      unique case (mode_c)
         PMDC_DUAL, PMDC_SYNTH: ct = osc_tick;
         PMDC_OSC_ONLY:         ct = vcxo_tick_i;
         PMDC_FANOUT:           ct = p1_tick;
         default:               ct = 1'b0;
      endcase
   end

   assign rst_in = q.resync | blk_pd_i[`PMDC_PD_INPUT];
   assign rst_l0 = q.resync | blk_pd_i[`PMDC_PD_LOOP0]
                   | (mode_c != PMDC_DUAL && mode_c != PMDC_OSC_ONLY);
   assign rst_l1 = q.resync | blk_pd_i[`PMDC_PD_LOOP1]
                   | (mode_c == PMDC_OSC_ONLY)
                   | (mode_c == PMDC_INVALID);
   assign rst_p1 = rst_l1 & ~(mode_c == PMDC_FANOUT && ~q.resync);

   pmdc_div u_rn (
      .clk_i     (clk_i),
      .rst_b_i   (rst_b_i),
      .restart_i (rst_in),
      .en_i      (sel_tick),
      .dbl_i     (1'b0),
      .ratio_i   (15'h1 << input_div_sel_i),
      .tick_o    (rn_tick),
      .chg_o     (loop_chg[0])
   );
   pmdc_div u_p0 (
      .clk_i     (clk_i),
      .rst_b_i   (rst_b_i),
      .restart_i (rst_in | rst_l0),
      .en_i      (rn_tick),
      .dbl_i     (1'b0),
      .ratio_i   (first_loop_pre_divider_i),
      .tick_o    (p0_tick),
      .chg_o     (loop_chg[1])
   );
   pmdc_div u_m1 (
      .clk_i     (clk_i),
      .rst_b_i   (rst_b_i),
      .restart_i (rst_l0 | rst_l1),
      .en_i      (osc_tick),
      .dbl_i     (1'b0),
      .ratio_i   ({1'b0, cascade_feedback_divider_i}),
      .tick_o    (m1_tick),
      .chg_o     (loop_chg[2])
   );
   // In dual mode only, route one closes the first loop through the cascade divider too
   pmdc_div u_m0 (
      .clk_i     (clk_i),
      .rst_b_i   (rst_b_i),
      .restart_i (rst_l0),
      .en_i      ((mode_c == PMDC_DUAL && first_loop_feedback_route_i)
                  ? m1_tick : vcxo_tick_i),
      .dbl_i     (1'b0),
      .ratio_i   (first_loop_feedback_divider_i),
      .tick_o    (m0_tick),
      .chg_o     (loop_chg[3])
   );
   pmdc_div u_p1 (
      .clk_i     (clk_i),
      .rst_b_i   (rst_b_i),
      .restart_i (rst_p1),
      .en_i      ((mode_c == PMDC_DUAL) ? vcxo_tick_i : rn_tick),
      .dbl_i     (second_loop_doubler_i & (mode_c != PMDC_FANOUT)),
      .ratio_i   ({8'h0, second_loop_pre_divider_i}),
      .tick_o    (p1_tick),
      .chg_o     (loop_chg[4])
   );
   pmdc_div u_m2 (
      .clk_i     (clk_i),
      .rst_b_i   (rst_b_i),
      .restart_i (rst_l1),
      .en_i      (osc_tick),
      .dbl_i     (1'b0),
      .ratio_i   ({5'h0, second_loop_feedback_divider_i}),
      .tick_o    (m2_tick),
      .chg_o     (loop_chg[5])
   );

   // One divider chain per output channel
   generate
      for (gi = 0; gi < `PMDC_NCH; gi++) begin : g_ch
         logic [2:0]  base_c;
         logic [3:0]  pow_c;
         logic [3:0]  srp_c;
         assign base_c = (ch_base_i[gi] == 3'h0) ? 3'h1
                       : (ch_base_i[gi] > `PMDC_BASE_MAX) ? `PMDC_BASE_MAX
                       : ch_base_i[gi];
         assign pow_c  = (ch_pow_i[gi] > `PMDC_POW_MAX) ? `PMDC_POW_MAX
                       : ch_pow_i[gi];
         assign srp_c  = (ch_sr_pow_i[gi] < `PMDC_SR_MIN) ? `PMDC_SR_MIN
                       : (ch_sr_pow_i[gi] > `PMDC_POW_MAX) ? `PMDC_POW_MAX
                       : ch_sr_pow_i[gi];
         assign ch_rst[gi] = q.resync | ch_pd_i[gi];
         assign ch_out[gi] = ch_sysref_i[gi] ? sr_tick[gi] : clk_tick[gi];

         pmdc_div u_base (
            .clk_i     (clk_i),
            .rst_b_i   (rst_b_i),
            .restart_i (ch_rst[gi]),
            .en_i      (ct),
            .dbl_i     (1'b0),
            .ratio_i   ({12'h0, base_c}),
            .tick_o    (base_tick[gi]),
            .chg_o     (ch_chg[3*gi])
         );
         pmdc_div u_pow (
            .clk_i     (clk_i),
            .rst_b_i   (rst_b_i),
            .restart_i (ch_rst[gi]),
            .en_i      (base_tick[gi]),
            .dbl_i     (1'b0),
            .ratio_i   (15'h1 << pow_c),
            .tick_o    (clk_tick[gi]),
            .chg_o     (ch_chg[3*gi+1])
         );

         // SYSREF shares the clock chain, so it stays edge-aligned
         pmdc_div u_sr (
            .clk_i     (clk_i),
            .rst_b_i   (rst_b_i),
            .restart_i (ch_rst[gi] | ~ch_sysref_i[gi]),
            .en_i      (clk_tick[gi]),
            .dbl_i     (1'b0),
            .ratio_i   (15'h1 << srp_c),
            .tick_o    (sr_tick[gi]),
            .chg_o     (ch_chg[3*gi+2])
         );
      end
   endgenerate

   always_comb begin
      d = q;
      for (int i = 0; i < 2; i++) begin
         d.ref_s[i]  = {q.ref_s[i][1:0], ref_in_i[i]};
         d.gpio_s[i] = {q.gpio_s[i][1:0], gpio_i[i]};
         if (q.ref_s[i][2] == q.ref_s[i][1]) begin
            d.ref_lvl[i] = q.ref_s[i][1];
         end
         if (q.gpio_s[i][2] == q.gpio_s[i][1]) begin
            d.gpio_lvl[i] = q.gpio_s[i][1];
         end
         // Activity monitor: no edge for the timeout marks the input lost
         if (ref_edge[i]) begin
            d.los_cnt[i] = '0;
            d.los[i]     = 1'b0;
         end else if (q.los_cnt[i] == `PMDC_LOS_LAST) begin
            d.los[i] = 1'b1;
         end else begin
            d.los_cnt[i] = q.los_cnt[i] + 7'h1;
         end
      end

      // Fanout mode has no auto switching; only the manual choice
      if (ref_mode_i == `PMDC_REF_MAN0 ||
          (mode_c == PMDC_FANOUT && ref_mode_i != `PMDC_REF_MAN1)) begin
         d.act_ref  = 1'b0;
         d.holdover = 1'b0;
      end else if (ref_mode_i == `PMDC_REF_MAN1) begin
         d.act_ref  = 1'b1;
         d.holdover = 1'b0;
      end else if (!q.los[ref_prio_i]) begin
         d.act_ref  = ref_prio_i;
         d.holdover = 1'b0;
      end else if (!q.los[~ref_prio_i]) begin
         d.act_ref  = ~ref_prio_i;
         d.holdover = 1'b0;
      end else begin
         d.holdover = 1'b1;
      end

      for (int i = 0; i < 2; i++) begin
         unique case (gpio_func_i[i])
            `PMDC_GPIO_IN, `PMDC_GPIO_CTRL: begin
               d.gpio_oe[i]  = 1'b0;
               d.gpio_pin[i] = 1'b0;
            end
            `PMDC_GPIO_OUT: begin
               d.gpio_oe[i]  = 1'b1;
               d.gpio_pin[i] = gpio_val_i[i];
            end
            `PMDC_GPIO_STAT: begin
               d.gpio_oe[i]  = 1'b1;
               d.gpio_pin[i] = (i == 0) ? q.holdover : |q.los;
            end
         endcase
      end

      if (vco_tick_i && ext_osc_halve_select_i) begin
         d.halve_ph = ~q.halve_ph;
      end

      // Any ratio change or control pulse realigns every divider
      d.resync = |loop_chg | |ch_chg
                 | (gpio_rise[0] & (gpio_func_i[0] == `PMDC_GPIO_CTRL))
                 | (gpio_rise[1] & (gpio_func_i[1] == `PMDC_GPIO_CTRL));

      if (ct) begin
         for (int c = 0; c < `PMDC_NCH; c++) begin
            d.ch_dly[c] = {q.ch_dly[c][`PMDC_DLY-2:0], ch_out[c]};
         end
         for (int o = 0; o < `PMDC_NOUT; o++) begin
            d.out_dly[o] = {q.out_dly[o][`PMDC_DLY-2:0],
                            q.ch_dly[o/2][ch_phase_i[o/2]]};
         end
      end
      if (q.resync) begin
         d.ch_dly  = '0;
         d.out_dly = '0;
      end
      for (int o = 0; o < `PMDC_NOUT; o++) begin
         d.q_out[o] = ct & ~out_pd_i[o] & ~ch_pd_i[o/2]
                      & q.out_dly[o][out_phase_i[o]];
      end

      d.mode    = mode_c;
      d.determ  = (mode_c == PMDC_DUAL) & first_loop_feedback_route_i;
      d.central = ct;
      d.pfd     = {m2_tick, p1_tick & (mode_c != PMDC_FANOUT),
                   m0_tick, p0_tick};
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         q      <= '0;
         q.mode <= PMDC_DUAL;
      end else begin
         q <= d;
      end
   end

   assign gpio_o          = q.gpio_pin;
   assign gpio_oe_o       = q.gpio_oe;
   assign gpio_in_o       = q.gpio_lvl;
   assign q_out_o         = q.q_out;
   assign mode_o          = q.mode;
   assign deterministic_o = q.determ;
   assign central_tick_o  = q.central;
   assign active_ref_o    = q.act_ref;
   assign holdover_o      = q.holdover;
   assign ref_los_o       = q.los;
   assign pfd0_ref_o      = q.pfd[0];
   assign pfd0_fb_o       = q.pfd[1];
   assign pfd1_ref_o      = q.pfd[2];
   assign pfd1_fb_o       = q.pfd[3];

endmodule // pmdc_top

/* File: test/pmdc_checker.sv */
`timescale 1ns/1ps
module pmdc_checker (
   input wire logic                 clk_i,
   input wire logic                 rst_b_i,
   input wire logic                 first_loop_bypass_i,
   input wire logic [1:0]           central_source_select_i,
   input wire logic                 first_loop_feedback_route_i,
   input wire logic [15:0]          out_pd_i,
   input wire logic [1:0][1:0]      gpio_func_i,
   input wire logic [1:0]           gpio_val_i,
   input wire logic [1:0]           gpio_o,
   input wire logic [1:0]           gpio_oe_o,
   input wire logic [15:0]          q_out_o,
   input wire pmdc_pkg::pmdc_mode_t mode_o,
   input wire logic                 deterministic_o,
   input wire logic                 central_tick_o
);
   import pmdc_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   wire       byp = first_loop_bypass_i;
   wire [1:0] src = central_source_select_i;

   a_mode_dual:
   assert property (!byp && !src[1] |=> mode_o == PMDC_DUAL) else $error("dual");
   a_mode_synth:
   assert property (byp && !src[1] |=> mode_o == PMDC_SYNTH) else $error("syn");
   a_mode_osc:
   assert property (src == 2'h2 |=> mode_o == PMDC_OSC_ONLY) else $error("osc");
   a_mode_fanout:
   assert property (byp && src == 2'h3 |=> mode_o == PMDC_FANOUT)
      else $error("fanout");
   a_invalid_idle:
   assert property ((!byp && src == 2'h3) [*3] |=>
      !central_tick_o && q_out_o == 16'h0000) else $error("invalid runs");
   a_determ_path:
   assert property (1'b1 |=> deterministic_o ==
      $past(!byp && !src[1] && first_loop_feedback_route_i))
      else $error("determ");
   a_pd_quiet:
   assert property ((q_out_o & $past(out_pd_i)) == 16'h0000) else $error("pd");
   a_tick_gate:
   assert property (q_out_o != 16'h0000 |-> central_tick_o) else $error("sync");
   a_gpio_drive:
   assert property (gpio_func_i[0] == 2'h1 |=>
      gpio_oe_o[0] && gpio_o[0] == $past(gpio_val_i[0])) else $error("gpo");
   a_gpio_listen:
   assert property (gpio_func_i[1] == 2'h0 |=> !gpio_oe_o[1]) else $error("gpi");
endmodule // pmdc_checker

bind pmdc_top pmdc_checker chk_u (.*);

/* File: test/pmdc_src_model.sv */
`timescale 1ns/1ps
module pmdc_src_model (
   input  wire logic       clk_i,
   input  wire logic [1:0] ref_en_i,
   output logic            vco_tick_o = 1'b0,
   output logic            vcxo_tick_o = 1'b0,
   output logic [1:0]      ref_o = 2'h0
);
   logic [1:0] cnt_q = 2'h0;
   // Fast oscillator ticks every cycle; a stopped reference freezes
   always @(posedge clk_i) begin
      cnt_q <= cnt_q + 2'h1;
      vco_tick_o <= 1'b1;
      vcxo_tick_o <= cnt_q == 2'h0;
      if (cnt_q == 2'h0) begin
         ref_o <= ref_o ^ ref_en_i;
      end
   end
endmodule // pmdc_src_model

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import pmdc_pkg::*;
   logic clk_i = 1'b0, rst_b_i = 1'b0, first_loop_bypass_i = 1'b0;
   logic first_loop_feedback_route_i = 1'b0, second_loop_doubler_i = 1'b0;
   logic ext_osc_halve_select_i = 1'b0, ref_prio_i = 1'b0;
   logic [1:0] central_source_select_i = 2'h0, input_div_sel_i = 2'h0;
   logic [1:0] ref_mode_i = 2'h0, gpio_val_i = 2'h0, gpio_i = 2'h0;
   logic [1:0] ref_en = 2'h3;
   logic [14:0] first_loop_pre_divider_i = 15'h0001;
   logic [14:0] first_loop_feedback_divider_i = 15'h0001;
   logic [13:0] cascade_feedback_divider_i = 14'h0008;
   logic [6:0] second_loop_pre_divider_i = 7'h01;
   logic [9:0] second_loop_feedback_divider_i = 10'h008;
   logic [7:0][2:0] ch_base_i = 24'h249acb;
   logic [7:0][3:0] ch_pow_i = 32'h00002101, ch_sr_pow_i = 32'h00000020;
   logic [7:0][3:0] ch_phase_i = '0;
   logic [15:0][3:0] out_phase_i = '0;
   logic [7:0] ch_sysref_i = 8'h02, ch_pd_i = 8'h00;
   logic [15:0] out_pd_i = 16'h0000, q_out_o;
   logic [2:0] blk_pd_i = 3'h0;
   logic [1:0][1:0] gpio_func_i = '0;
   logic [1:0] ref_in_i, gpio_o, gpio_oe_o, gpio_in_o, ref_los_o;
   logic vcxo_tick_i, vco_tick_i, deterministic_o, central_tick_o;
   logic active_ref_o, holdover_o, pfd0_ref_o, pfd0_fb_o, pfd1_ref_o, pfd1_fb_o;
   pmdc_mode_t mode_o;
   int num_errors = 0, num_checks = 0, cyc = 0;
   wire [19:0] probe = {pfd1_fb_o, pfd1_ref_o, pfd0_fb_o, pfd0_ref_o, q_out_o};

   pmdc_top dut_u (.*);
   pmdc_src_model src_u (.clk_i(clk_i), .ref_en_i(ref_en),
      .vco_tick_o(vco_tick_i), .vcxo_tick_o(vcxo_tick_i), .ref_o(ref_in_i));

   always #25 clk_i = ~clk_i;

   task automatic complete_run();
      if (num_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         num_errors++;
         complete_run();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Cycles from a pulse on probe bit a to the next pulse on bit b
   task automatic gap(input int a, input int b, input int e);
      int n;
      n = 0;
      repeat (6) @(negedge clk_i);
      do @(negedge clk_i); while (probe[a] !== 1'b1);
      do begin
         @(negedge clk_i);
         n++;
      end while (probe[b] !== 1'b1);
      chk(16'(n), 16'(e));
   endtask

   task automatic t_modes();
      logic [3:0] v;
      pmdc_mode_t e;
      for (int i = 0; i < 16; i++) begin
         v = 4'(i);
         @(posedge clk_i);
         first_loop_bypass_i <= v[0];
         central_source_select_i <= v[2:1];
         first_loop_feedback_route_i <= v[3];
         e = !v[2] ? (v[0] ? PMDC_SYNTH : PMDC_DUAL) : !v[1] ? PMDC_OSC_ONLY
            : v[0] ? PMDC_FANOUT : PMDC_INVALID;
         repeat (3) @(negedge clk_i);
         chk(16'(mode_o), 16'(e));
         chk(16'(deterministic_o), 16'(!v[0] && !v[2] && v[3]));
      end
   endtask

   task automatic t_outs();
      @(posedge clk_i);
      first_loop_bypass_i <= 1'b0;
      central_source_select_i <= 2'h0;
      first_loop_feedback_route_i <= 1'b0;
      gap(0, 0, 6);
      gap(6, 6, 20);
      gap(2, 2, 4);
      gap(4, 4, 6);
      @(posedge clk_i);
      out_phase_i[1] <= 4'h3;
      ch_phase_i[2] <= 4'h2;
      gap(0, 1, 3);
      gap(0, 4, 2);
      @(posedge clk_i);
      ch_base_i[2] <= 3'h5;
      @(posedge clk_i);
      ch_base_i[2] <= 3'h3;
      gap(0, 4, 2);
      @(posedge clk_i);
      ext_osc_halve_select_i <= 1'b1;
      gap(0, 0, 12);
      @(posedge clk_i);
      ext_osc_halve_select_i <= 1'b0;
   endtask

   task automatic t_pd();
      @(posedge clk_i);
      out_pd_i[0] <= 1'b1;
      ch_pd_i[1] <= 1'b1;
      blk_pd_i <= 3'h4;
      repeat (20) @(posedge clk_i);
      repeat (30) begin
         @(negedge clk_i);
         chk(q_out_o & 16'h000d, 16'h0000);
         chk(16'({pfd1_fb_o, pfd1_ref_o}), 16'h0000);
      end
      gap(1, 1, 6);
      @(posedge clk_i);
      out_pd_i[0] <= 1'b0;
      ch_pd_i[1] <= 1'b0;
      blk_pd_i <= 3'h0;
   endtask

   task automatic t_pfd();
      @(posedge clk_i);
      input_div_sel_i <= 2'h1;
      first_loop_pre_divider_i <= 15'h0003;
      first_loop_feedback_divider_i <= 15'h0005;
      second_loop_pre_divider_i <= 7'h7f;
      second_loop_feedback_divider_i <= 10'h3ff;
      gap(16, 16, 48);
      gap(17, 17, 20);
      gap(18, 18, 508);
      gap(19, 19, 1023);
      @(posedge clk_i);
      second_loop_pre_divider_i <= 7'h04;
      second_loop_doubler_i <= 1'b1;
      first_loop_feedback_route_i <= 1'b1;
      cascade_feedback_divider_i <= 14'h0008;
      gap(18, 18, 8);
      gap(17, 17, 40);
   endtask

   task automatic t_gpio();
      @(posedge clk_i);
      gpio_func_i <= {2'h2, 2'h1};
      gpio_val_i <= 2'h1;
      gpio_i <= 2'h2;
      repeat (6) @(negedge clk_i);
      chk(16'({gpio_oe_o, gpio_o[0], gpio_in_o[1]}), 16'h0007);
      // Control edge restarts channel 0, so no pulse for eight cycles
      repeat (8) begin
         @(negedge clk_i);
         chk(16'(q_out_o[0]), 16'h0000);
      end
   endtask

   task automatic t_ref();
      logic [1:0] en [3] = '{2'h3, 2'h1, 2'h0};
      logic [4:0] ex [3] = '{5'h08, 5'h05, 5'h17};
      @(posedge clk_i);
      ref_mode_i <= 2'h2;
      ref_prio_i <= 1'b1;
      gpio_func_i <= {2'h3, 2'h1};
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_i);
         ref_en <= en[i];
         repeat (100) @(negedge clk_i);
         chk(16'({holdover_o, active_ref_o, ref_los_o, gpio_o[1]}),
            16'(ex[i]));
      end
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      t_modes();
      t_outs();
      t_pd();
      t_pfd();
      t_gpio();
      t_ref();
      complete_run();
   end
endmodule // tb_top
